// ===== hw/sdmra_pkg.sv
// Shared constants and types for the mode register access block.
package sdmra_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int READ_LATENCY = 3;
    localparam int CA_W = 10;
    localparam int DQ_W = 32;
    localparam int LANES = 4;
    localparam int TIMER_W = 12;

    // Command encodings on CA3..CA0 at the rising edge.
    localparam logic [3:0] CMD_REG_READ = 4'h8;
    localparam logic [3:0] CMD_REG_WRITE = 4'h0;

    // Register addresses.
    localparam logic [7:0] ADDR_CFG_BASE = 8'h01;
    localparam int CFG_COUNT = 3;
    localparam logic [7:0] ADDR_TEMPERATURE_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IMPEDANCE_CAL = 8'h0A;
    localparam logic [7:0] ADDR_CAL_PATTERN_A = 8'h20;
    localparam logic [7:0] ADDR_CAL_PATTERN_B = 8'h28;
    localparam logic [7:0] ADDR_REG_RESET = 8'h3F;

    // Reset values of the writable configuration registers, entry 0 in the low byte.
    localparam logic [23:0] CFG_RESET_VALUES = 24'h000000;

    // Calibration patterns, bit n is the value of beat n.
    localparam logic [3:0] PATTERN_A = 4'h5;
    localparam logic [3:0] PATTERN_B = 4'hC;

    // Impedance calibration command codes.
    localparam logic [7:0] CAL_CODE_INIT = 8'hFF;
    localparam logic [7:0] CAL_CODE_LONG = 8'hAB;
    localparam logic [7:0] CAL_CODE_SHORT = 8'h56;
    localparam logic [7:0] CAL_CODE_RESET = 8'hC3;

    // Operation times and their cycle counts (least times round up).
    localparam int WRITE_PERIOD_CYC = 5;
    localparam int INIT_CAL_NS = 1000;
    localparam int LONG_CAL_NS = 400;
    localparam int SHORT_CAL_NS = 100;
    localparam int DEFAULT_RESET_NS = 50;
    localparam int AUTO_INIT_NS = 1000;
    localparam int INIT_CAL_CYC = (INIT_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_CAL_CYC = (LONG_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_CAL_CYC = (SHORT_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEFAULT_RESET_CYC = (DEFAULT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUTO_INIT_CYC = (AUTO_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sensor update interval is a longest time, so it rounds down.
    localparam int SENSOR_UPDATE_MS = 32;
    localparam int SENSOR_UPDATE_CYC = (SENSOR_UPDATE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int SENSOR_CNT_W = 22;

    typedef enum logic [1:0] {
        SDMRA_IDLE = 2'b00,
        SDMRA_WRITE_PERIOD = 2'b01,
        SDMRA_AUTO_INIT = 2'b10,
        SDMRA_CALIBRATE = 2'b11
    } sdmra_state_t;

    typedef enum logic [1:0] {
        SDMRA_CAL_INIT = 2'b00,
        SDMRA_CAL_RESET = 2'b01,
        SDMRA_CAL_LONG = 2'b10,
        SDMRA_CAL_SHORT = 2'b11
    } sdmra_cal_op_t;

endpackage : sdmra_pkg

// ===== hw/sdmra_op_timer.sv
// Down-counter that times the write, reset and calibration periods.
`timescale 1ns/1ns
`default_nettype none
module sdmra_op_timer
    import sdmra_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [sdmra_pkg::TIMER_W-1:0] count_in,
    output logic busy_out,
    output logic done_out
);
    import sdmra_pkg::*;

    logic [TIMER_W-1:0] cnt_q;
    logic [TIMER_W-1:0] cnt_d;
    logic busy_d;
    logic done_d;

    always_comb
    begin
        cnt_d = cnt_q;
        busy_d = busy_out;
        done_d = 1'b0;
        if (load_in)
        begin
            cnt_d = count_in;
            busy_d = 1'b1;
        end
        else if (busy_out)
        begin
            if (cnt_q <= TIMER_W'(1))
            begin
                cnt_d = '0;
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q - TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            busy_out <= busy_d;
            done_out <= done_d;
        end
    end

endmodule : sdmra_op_timer
`default_nettype wire

// ===== hw/sdmra_core.sv
// Mode register read, write, reset and calibration command handling.
//
// Summary of operation
// - Read: select low, CA3..0 = 1000.
// - Register value on low byte, strobes toggle.
// - Read bursts are four beats over two cycles.
// - Other beats and upper lanes undefined.
// - A read one cycle after another cuts the earlier burst to two beats.
// - Temperature status refreshed within interval.
// - Pattern repeated on every lane bit.
// - Pattern A 1010, pattern B 0011.
// - Write: select low, CA3..0 all low.
// - Writes to read-only registers change nothing.
// - Writes rejected while any bank active.
// - Reset write restores defaults, auto-initializes.
// - Calibration register launches four operations.
`timescale 1ns/1ns
`default_nettype none
module sdmra_core
    import sdmra_pkg::*;
#(
    parameter int SENSOR_UPDATE_CYCLES = sdmra_pkg::SENSOR_UPDATE_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic select_n_in,
    input wire logic [sdmra_pkg::CA_W-1:0] ca_rise_in,
    input wire logic [sdmra_pkg::CA_W-1:0] ca_fall_in,
    input wire logic banks_active_in,
    input wire logic [2:0] temp_level_in,
    output logic [sdmra_pkg::DQ_W-1:0] dq_rise_out,
    output logic [sdmra_pkg::DQ_W-1:0] dq_fall_out,
    output logic dq_oe_out,
    output logic [sdmra_pkg::LANES-1:0] dqs_oe_out,
    output sdmra_pkg::sdmra_state_t op_state_out,
    output sdmra_pkg::sdmra_cal_op_t cal_op_out,
    output logic write_reject_out
);
    import sdmra_pkg::*;

    localparam int PIPE = READ_LATENCY - 1;

    // Register value returned by a read of the given address.
    function automatic logic [7:0] reg_value(input logic [7:0] addr,
                                             input logic [8*CFG_COUNT-1:0] cfg,
                                             input logic [2:0] temp);
        logic [7:0] idx;
        idx = addr - ADDR_CFG_BASE;
        reg_value = 8'h00;
        if (addr == ADDR_TEMPERATURE_STATUS)
        begin
            reg_value = {5'h00, temp};
        end
        else if (addr >= ADDR_CFG_BASE && idx < 8'(CFG_COUNT))
        begin
            reg_value = cfg[8*idx +: 8];
        end
    endfunction : reg_value

    // Lane word for one beat of a read burst.
    function automatic logic [DQ_W-1:0] beat_word(input logic [7:0] addr,
                                                  input logic [7:0] value,
                                                  input int beat);
        beat_word = '0;
        if (addr == ADDR_CAL_PATTERN_A)
        begin
            beat_word = {DQ_W{PATTERN_A[beat]}};
        end
        else if (addr == ADDR_CAL_PATTERN_B)
        begin
            beat_word = {DQ_W{PATTERN_B[beat]}};
        end
        else if (beat == 0)
        begin
            beat_word = {24'h000000, value};
        end
    endfunction : beat_word

    sdmra_state_t state_q, state_d;
    sdmra_cal_op_t cal_op_q, cal_op_d;
    logic [8*CFG_COUNT-1:0] cfg_q, cfg_d;
    logic [2:0] temp_q, temp_d;
    logic [SENSOR_CNT_W-1:0] sensor_cnt_q, sensor_cnt_d;
    logic sensor_first_q, sensor_first_d;
    logic reject_d;
    logic [PIPE-1:0] pipe_valid_q, pipe_valid_d;
    logic [7:0] pipe_addr_q [PIPE];
    logic [7:0] pipe_addr_d [PIPE];
    logic [7:0] pipe_data_q [PIPE];
    logic [7:0] pipe_data_d [PIPE];
    logic tail_q, tail_d;
    logic [DQ_W-1:0] tail_rise_q, tail_rise_d, tail_fall_q, tail_fall_d;
    logic [DQ_W-1:0] dq_rise_d, dq_fall_d;
    logic dq_oe_d;
    logic timer_load;
    logic [TIMER_W-1:0] timer_count;
    logic timer_busy;
    logic timer_done;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_data;
    logic is_read;
    logic is_write;
    logic [7:0] cfg_idx;

    assign cmd_addr = {ca_fall_in[1:0], ca_rise_in[9:4]};
    assign cmd_data = ca_fall_in[9:2];
    assign is_read = !select_n_in && ca_rise_in[3:0] == CMD_REG_READ;
    assign is_write = !select_n_in && ca_rise_in[3:0] == CMD_REG_WRITE;
    assign cfg_idx = cmd_addr - ADDR_CFG_BASE;

    sdmra_op_timer u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(timer_load),
        .count_in(timer_count),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );

    // Command decode and the write, reset and calibration sequencing.
    always_comb
    begin
        state_d = state_q;
        cal_op_d = cal_op_q;
        cfg_d = cfg_q;
        reject_d = 1'b0;
        timer_load = 1'b0;
        timer_count = TIMER_W'(WRITE_PERIOD_CYC);
        if (state_q != SDMRA_IDLE)
        begin
            if (timer_done && !timer_busy)
            begin
                state_d = SDMRA_IDLE;
            end
        end
        else if (is_write)
        begin
            if (banks_active_in)
            begin
                reject_d = 1'b1;
            end
            else if (cmd_addr == ADDR_REG_RESET)
            begin
                cfg_d = CFG_RESET_VALUES;
                state_d = SDMRA_AUTO_INIT;
                timer_load = 1'b1;
                timer_count = TIMER_W'(AUTO_INIT_CYC);
            end
            else if (cmd_addr == ADDR_IMPEDANCE_CAL)
            begin
                timer_load = 1'b1;
                state_d = SDMRA_CALIBRATE;
                case (cmd_data)
                    CAL_CODE_INIT:
                    begin
                        cal_op_d = SDMRA_CAL_INIT;
                        timer_count = TIMER_W'(INIT_CAL_CYC);
                    end
                    CAL_CODE_RESET:
                    begin
                        cal_op_d = SDMRA_CAL_RESET;
                        timer_count = TIMER_W'(DEFAULT_RESET_CYC);
                    end
                    CAL_CODE_LONG:
                    begin
                        cal_op_d = SDMRA_CAL_LONG;
                        timer_count = TIMER_W'(LONG_CAL_CYC);
                    end
                    CAL_CODE_SHORT:
                    begin
                        cal_op_d = SDMRA_CAL_SHORT;
                        timer_count = TIMER_W'(SHORT_CAL_CYC);
                    end
                    default:
                    begin
                        state_d = SDMRA_WRITE_PERIOD;
                    end
                endcase
            end
            else
            begin
                timer_load = 1'b1;
                state_d = SDMRA_WRITE_PERIOD;
                // Read-only and unmapped addresses only run the write period.
                if (cmd_addr >= ADDR_CFG_BASE && cfg_idx < 8'(CFG_COUNT))
                begin
                    cfg_d[8*cfg_idx +: 8] = cmd_data;
                end
            end
        end
    end

    // Temperature status sampling on a fixed update interval.
    always_comb
    begin
        temp_d = temp_q;
        sensor_first_d = 1'b0;
        sensor_cnt_d = sensor_cnt_q - SENSOR_CNT_W'(1);
        if (sensor_first_q || sensor_cnt_q == '0)
        begin
            temp_d = temp_level_in;
            sensor_cnt_d = SENSOR_CNT_W'(SENSOR_UPDATE_CYCLES - 1);
        end
    end

    // Read latency pipeline and the two-cycle, four-beat output burst.
    always_comb
    begin
        pipe_valid_d = {pipe_valid_q[PIPE-2:0], 1'b0};
        pipe_addr_d[0] = cmd_addr;
        pipe_data_d[0] = reg_value(cmd_addr, cfg_q, temp_q);
        for (int i = 1; i < PIPE; i++)
        begin
            pipe_addr_d[i] = pipe_addr_q[i-1];
            pipe_data_d[i] = pipe_data_q[i-1];
        end
        // Reads are served in any bank state but not during reset or calibration.
        pipe_valid_d[0] = is_read && state_q != SDMRA_AUTO_INIT
                          && state_q != SDMRA_CALIBRATE;
        tail_d = 1'b0;
        tail_rise_d = '0;
        tail_fall_d = '0;
        dq_rise_d = '0;
        dq_fall_d = '0;
        dq_oe_d = 1'b0;
        if (pipe_valid_q[PIPE-1])
        begin
            dq_oe_d = 1'b1;
            dq_rise_d = beat_word(pipe_addr_q[PIPE-1], pipe_data_q[PIPE-1], 0);
            dq_fall_d = beat_word(pipe_addr_q[PIPE-1], pipe_data_q[PIPE-1], 1);
            tail_d = 1'b1;
            tail_rise_d = beat_word(pipe_addr_q[PIPE-1], pipe_data_q[PIPE-1], 2);
            tail_fall_d = beat_word(pipe_addr_q[PIPE-1], pipe_data_q[PIPE-1], 3);
        end
        else if (tail_q)
        begin
            dq_oe_d = 1'b1;
            dq_rise_d = tail_rise_q;
            dq_fall_d = tail_fall_q;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= SDMRA_IDLE;
            cal_op_q <= SDMRA_CAL_INIT;
            cfg_q <= CFG_RESET_VALUES;
            write_reject_out <= 1'b0;
            temp_q <= 3'h0;
            sensor_cnt_q <= '0;
            sensor_first_q <= 1'b1;
            pipe_valid_q <= '0;
            for (int i = 0; i < PIPE; i++)
            begin
                pipe_addr_q[i] <= 8'h00;
                pipe_data_q[i] <= 8'h00;
            end
            tail_q <= 1'b0;
            tail_rise_q <= '0;
            tail_fall_q <= '0;
            dq_rise_out <= '0;
            dq_fall_out <= '0;
            dq_oe_out <= 1'b0;
            dqs_oe_out <= '0;
            op_state_out <= SDMRA_IDLE;
            cal_op_out <= SDMRA_CAL_INIT;
        end
        else
        begin
            state_q <= state_d;
            cal_op_q <= cal_op_d;
            cfg_q <= cfg_d;
            write_reject_out <= reject_d;
            temp_q <= temp_d;
            sensor_cnt_q <= sensor_cnt_d;
            sensor_first_q <= sensor_first_d;
            pipe_valid_q <= pipe_valid_d;
            pipe_addr_q <= pipe_addr_d;
            pipe_data_q <= pipe_data_d;
            tail_q <= tail_d;
            tail_rise_q <= tail_rise_d;
            tail_fall_q <= tail_fall_d;
            dq_rise_out <= dq_rise_d;
            dq_fall_out <= dq_fall_d;
            dq_oe_out <= dq_oe_d;
            dqs_oe_out <= {LANES{dq_oe_d}};
            op_state_out <= state_d;
            cal_op_out <= cal_op_d;
        end
    end

endmodule : sdmra_core
`default_nettype wire

// ===== verif/sdmra_props.sv
// Checker for the mode register access block ports.
`timescale 1ns/1ns
`default_nettype none
module sdmra_props
    import sdmra_pkg::*;
#(
    parameter int SENSOR_UPDATE_CYCLES = 20
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic select_n_in,
    input wire logic [sdmra_pkg::CA_W-1:0] ca_rise_in,
    input wire logic [sdmra_pkg::CA_W-1:0] ca_fall_in,
    input wire logic banks_active_in,
    input wire logic [2:0] temp_level_in,
    input wire logic [sdmra_pkg::DQ_W-1:0] dq_rise_out,
    input wire logic [sdmra_pkg::DQ_W-1:0] dq_fall_out,
    input wire logic dq_oe_out,
    input wire logic [sdmra_pkg::LANES-1:0] dqs_oe_out,
    input wire sdmra_pkg::sdmra_state_t op_state_out,
    input wire sdmra_pkg::sdmra_cal_op_t cal_op_out,
    input wire logic write_reject_out
);
    logic [7:0] adr;
    logic rd, wr, wc, hit;
    sdmra_cal_op_t exp_d, exp_q;
    assign adr = {ca_fall_in[1:0], ca_rise_in[9:4]};
    assign rd = !select_n_in && ca_rise_in[3:0] == CMD_REG_READ && !op_state_out[1];
    assign wc = !select_n_in && ca_rise_in[3:0] == CMD_REG_WRITE && op_state_out == SDMRA_IDLE;
    assign wr = wc && !banks_active_in;
    always_comb
    begin
        hit = wr && adr == ADDR_IMPEDANCE_CAL;
        exp_d = exp_q;
        case (ca_fall_in[9:2])
            CAL_CODE_INIT: exp_d = SDMRA_CAL_INIT;
            CAL_CODE_RESET: exp_d = SDMRA_CAL_RESET;
            CAL_CODE_LONG: exp_d = SDMRA_CAL_LONG;
            CAL_CODE_SHORT: exp_d = SDMRA_CAL_SHORT;
            default: hit = 1'b0;
        endcase
        if (!hit)
            exp_d = exp_q;
    end
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            exp_q <= SDMRA_CAL_INIT;
        else
            exp_q <= exp_d;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    read_latency_a: assert property (rd |-> ##3 dq_oe_out ##1 dq_oe_out)
        else $error("read burst timing wrong");
    burst_start_a: assert property ($rose(dq_oe_out) |-> $past(rd, 3))
        else $error("burst without read");
    strobe_follow_a: assert property (dqs_oe_out == {4{dq_oe_out}})
        else $error("strobes do not follow burst");
    pattern_a_a: assert property (rd && adr == ADDR_CAL_PATTERN_A |-> ##3
        (&dq_rise_out && dq_fall_out == 32'h0) ##1 (&dq_rise_out && dq_fall_out == 32'h0))
        else $error("pattern A wrong");
    pattern_b_a: assert property (rd && adr == ADDR_CAL_PATTERN_B |-> ##3
        (dq_rise_out == 32'h0 && dq_fall_out == 32'h0) ##1 (&dq_rise_out && &dq_fall_out))
        else $error("pattern B wrong");
    upper_lanes_a: assert property (rd && adr[7:4] != 4'h2 |-> ##3
        (dq_rise_out[31:8] == 24'h0 && dq_fall_out == 32'h0)
        ##1 (dq_rise_out == 32'h0 && dq_fall_out == 32'h0))
        else $error("undefined lanes not zero");
    idle_bus_a: assert property (!dq_oe_out |-> dq_rise_out == 32'h0 && dq_fall_out == 32'h0)
        else $error("data driven outside burst");
    reject_pulse_a: assert property (wc && banks_active_in |=>
        write_reject_out && op_state_out == SDMRA_IDLE ##1 !write_reject_out)
        else $error("write not rejected");
    write_period_a: assert property (wr && adr >= ADDR_CFG_BASE && adr < 8'h04 |=>
        (op_state_out == SDMRA_WRITE_PERIOD)[*4] ##[1:4] op_state_out == SDMRA_IDLE)
        else $error("write period wrong");
    reset_write_a: assert property (wr && adr == ADDR_REG_RESET |=>
        (op_state_out == SDMRA_AUTO_INIT)[*8] ##[85:100] op_state_out == SDMRA_IDLE)
        else $error("auto initialization wrong");
    cal_launch_a: assert property (hit |->
        ##[1:8] (op_state_out == SDMRA_CALIBRATE && cal_op_out == exp_q))
        else $error("calibration not launched");
    read_c: cover property (rd ##3 dq_oe_out);
    reject_c: cover property (wc && banks_active_in);
    cal_c: cover property (hit);
    auto_init_c: cover property (wr && adr == ADDR_REG_RESET);
endmodule : sdmra_props
bind sdmra_core sdmra_props #(.SENSOR_UPDATE_CYCLES(SENSOR_UPDATE_CYCLES)) sdmra_props_i (
    .clk_in(clk_in), .rst_in(rst_in), .select_n_in(select_n_in), .ca_rise_in(ca_rise_in),
    .ca_fall_in(ca_fall_in), .banks_active_in(banks_active_in), .temp_level_in(temp_level_in),
    .dq_rise_out(dq_rise_out), .dq_fall_out(dq_fall_out), .dq_oe_out(dq_oe_out),
    .dqs_oe_out(dqs_oe_out), .op_state_out(op_state_out), .cal_op_out(cal_op_out),
    .write_reject_out(write_reject_out));
`default_nettype wire

// ===== verif/sdmra_ctrl_model.sv
// Memory controller model that issues register commands.
`timescale 1ns/1ns
`default_nettype none
module sdmra_ctrl_model
    import sdmra_pkg::*;
#(
    parameter int RD_TO_WR = 7
)
(
    input wire logic clk_in,
    input wire sdmra_pkg::sdmra_state_t state_in,
    output logic select_n_out,
    output logic [sdmra_pkg::CA_W-1:0] ca_rise_out,
    output logic [sdmra_pkg::CA_W-1:0] ca_fall_out,
    output logic banks_active_out
);
    int since_rd = 100;
    initial
    begin
        select_n_out = 1'b1;
        ca_rise_out = 10'h000;
        ca_fall_out = 10'h000;
        banks_active_out = 1'b0;
    end
    // Counts cycles since the last register read was sampled by the device.
    always @(posedge clk_in)
    begin
        if (!select_n_out && ca_rise_out[3:0] == CMD_REG_READ)
            since_rd <= 1;
        else
            since_rd <= since_rd + 1;
    end
    // One command, then no-ops; no data bursts are ever issued, so only register spacing applies.
    task automatic cmd(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        #1;
        while ((wr && since_rd < RD_TO_WR) || state_in != SDMRA_IDLE)
        begin
            @(posedge clk_in);
            #1;
        end
        select_n_out = 1'b0;
        ca_rise_out = {addr[5:0], wr ? CMD_REG_WRITE : CMD_REG_READ};
        ca_fall_out = {data, addr[7:6]};
        @(posedge clk_in);
        #1;
        select_n_out = 1'b1;
        ca_rise_out = ~ca_rise_out;
        ca_fall_out = ~ca_fall_out;
    endtask : cmd
    // Banks stay idle unless a scenario asks otherwise.
    task automatic set_banks(input logic v);
        @(posedge clk_in);
        #1;
        banks_active_out = v;
    endtask : set_banks
endmodule : sdmra_ctrl_model
`default_nettype wire

// ===== verif/sdmra_core_tb.sv
// Self-checking bench for the mode register access block.
`timescale 1ns/1ns
`default_nettype none
module sdmra_core_tb;
    import sdmra_pkg::*;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data;} sdmra_row_t;
    localparam int SENS = 20;
    logic clk_in = 1'b0, rst_in = 1'b1, sel_n, bact, dq_oe, rej;
    logic [2:0] temp = 3'h3;
    logic [9:0] car, caf;
    logic [31:0] dqr, dqf;
    logic [3:0] dqs_oe;
    sdmra_state_t st;
    sdmra_cal_op_t cop;
    int error_cnt = 0, checks = 0, cyc = 0, n;
    sdmra_row_t rows[12] = '{'{1, 8'h01, 8'h5A}, '{1, 8'h02, 8'hA5}, '{1, 8'h03, 8'hFF},
        '{0, 8'h01, 8'h5A}, '{0, 8'h02, 8'hA5}, '{0, 8'h03, 8'hFF}, '{1, 8'h04, 8'h77},
        '{1, 8'h20, 8'h13}, '{0, 8'h0A, 8'h00}, '{0, 8'h20, 8'h00}, '{0, 8'h28, 8'h00},
        '{0, 8'h04, 8'h03}};
    logic [7:0] codes[4] = '{CAL_CODE_INIT, CAL_CODE_RESET, CAL_CODE_LONG, CAL_CODE_SHORT};
    sdmra_cal_op_t ops[4] = '{SDMRA_CAL_INIT, SDMRA_CAL_RESET, SDMRA_CAL_LONG, SDMRA_CAL_SHORT};
    int cycs[4] = '{INIT_CAL_CYC, DEFAULT_RESET_CYC, LONG_CAL_CYC, SHORT_CAL_CYC};
    sdmra_core #(.SENSOR_UPDATE_CYCLES(SENS)) sdmra_core_i (.clk_in(clk_in), .rst_in(rst_in),
        .select_n_in(sel_n), .ca_rise_in(car), .ca_fall_in(caf), .banks_active_in(bact),
        .temp_level_in(temp), .dq_rise_out(dqr), .dq_fall_out(dqf), .dq_oe_out(dq_oe),
        .dqs_oe_out(dqs_oe), .op_state_out(st), .cal_op_out(cop), .write_reject_out(rej));
    sdmra_ctrl_model sdmra_ctrl_model_i (.clk_in(clk_in), .state_in(st), .select_n_out(sel_n),
        .ca_rise_out(car), .ca_fall_out(caf), .banks_active_out(bact));
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Issues a read and compares both data cycles of the four-beat burst.
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [3:0] b;
        logic [31:0] e[4];
        b = addr == ADDR_CAL_PATTERN_A ? 4'b0101 : 4'b1100;
        for (int i = 0; i < 4; i++)
            e[i] = (addr == ADDR_CAL_PATTERN_A || addr == ADDR_CAL_PATTERN_B) ? {32{b[i]}} : 32'h0;
        if (addr != ADDR_CAL_PATTERN_A && addr != ADDR_CAL_PATTERN_B)
            e[0] = {24'h0, exp};
        sdmra_ctrl_model_i.cmd(1'b0, addr, 8'h00);
        repeat (2) @(posedge clk_in);
        #1;
        chk({27'h0, dq_oe, dqs_oe}, 32'h1F);
        chk(dqr, e[0]);
        chk(dqf, e[1]);
        @(posedge clk_in);
        #1;
        chk(dqr, e[2]);
        chk(dqf, e[3]);
        @(posedge clk_in);
        #1;
        chk({27'h0, dq_oe, dqs_oe}, 32'h0);
    endtask : rd_chk
    task automatic wait_idle();
        n = 0;
        while (st !== SDMRA_IDLE && n < 300)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask : wait_idle
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        chk({28'h0, st, rej, dq_oe}, 32'h0);
        sdmra_ctrl_model_i.cmd(1'b1, ADDR_IMPEDANCE_CAL, CAL_CODE_INIT);
        wait_idle();
        chk({30'h0, cop}, {30'h0, SDMRA_CAL_INIT});
        foreach (rows[i])
        begin
            if (rows[i].wr)
            begin
                sdmra_ctrl_model_i.cmd(1'b1, rows[i].addr, rows[i].data);
                chk({31'h0, rej}, 32'h0);
            end
            else
                rd_chk(rows[i].addr, rows[i].data);
        end
        sdmra_ctrl_model_i.set_banks(1'b1);
        rd_chk(8'h02, 8'hA5);
        sdmra_ctrl_model_i.cmd(1'b1, 8'h01, 8'h00);
        chk({31'h0, rej}, 32'h1);
        sdmra_ctrl_model_i.set_banks(1'b0);
        rd_chk(8'h01, 8'h5A);
        for (int k = 0; k < 4; k++)
        begin
            sdmra_ctrl_model_i.cmd(1'b1, ADDR_IMPEDANCE_CAL, codes[k]);
            n = 0;
            while (st !== SDMRA_CALIBRATE && n < 8)
            begin
                @(posedge clk_in);
                #1;
                n++;
            end
            chk({30'h0, cop}, {30'h0, ops[k]});
            n = 0;
            while (st === SDMRA_CALIBRATE && n < 300)
            begin
                @(posedge clk_in);
                #1;
                n++;
            end
            chk({31'h0, n >= cycs[k] && n <= cycs[k] + 2}, 32'h1);
        end
        sdmra_ctrl_model_i.cmd(1'b1, ADDR_IMPEDANCE_CAL, 8'h11);
        wait_idle();
        chk({30'h0, cop}, {30'h0, SDMRA_CAL_SHORT});
        temp = 3'h6;
        repeat (SENS + 5) @(posedge clk_in);
        rd_chk(ADDR_TEMPERATURE_STATUS, 8'h06);
        sdmra_ctrl_model_i.cmd(1'b1, ADDR_REG_RESET, 8'h00);
        chk({30'h0, st}, {30'h0, SDMRA_AUTO_INIT});
        wait_idle();
        chk({31'h0, n >= AUTO_INIT_CYC && n <= AUTO_INIT_CYC + 2}, 32'h1);
        rd_chk(8'h01, 8'h00);
        sdmra_ctrl_model_i.cmd(1'b1, 8'h02, 8'h33);
        rst_in = 1'b1;
        @(posedge clk_in);
        #1;
        chk({28'h0, st, rej, dq_oe}, 32'h0);
        rst_in = 1'b0;
        rd_chk(8'h02, 8'h00);
        stop_test();
    end
endmodule : sdmra_core_tb
`default_nettype wire
